/* File: verilog/tcs_pkg.sv */
// tcs_pkg: constants and carrier types of the transmit command/status block
// assumes: 32-bit APB register window, byte addresses in the low 8 bits
package tcs_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CMD     = 8'h00;
	localparam logic [7:0] ADDR_DESC    = 8'h04;
	localparam logic [7:0] ADDR_COUNT   = 8'h08;
	localparam logic [7:0] ADDR_CFG     = 8'h0C;
	localparam logic [7:0] ADDR_STATUS  = 8'h10;
	localparam logic [7:0] ADDR_CTRL    = 8'h14;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h1C;
	// command word fields, bits 31:16 of the command block word
	localparam int         CMD_CODE_LSB = 16;
	localparam logic [2:0] CMD_TX       = 3'h4;
	localparam int         FLEX_BIT     = 19;
	localparam int         NOCRC_BIT    = 20;
	localparam logic [31:0] DESC_NONE   = 32'hFFFFFFFF;
	// configuration bits
	localparam int CFG_CRC_BIT   = 0;
	localparam int CFG_NOCRS_BIT = 1;
	// status word masks
	localparam logic [15:0] M_DONE  = 16'h8000;
	localparam logic [15:0] M_BUSY  = 16'h4000;
	localparam logic [15:0] M_OK    = 16'h2000;
	localparam logic [15:0] M_ABORT = 16'h1000;
	localparam logic [15:0] M_LATE  = 16'h0800;
	localparam logic [15:0] M_NOCRS = 16'h0400;
	localparam logic [15:0] M_CTS   = 16'h0200;
	localparam logic [15:0] M_UNDER = 16'h0100;
	localparam logic [15:0] M_DEFER = 16'h0080;
	localparam logic [15:0] M_RETRY = 16'h0020;
	localparam logic [15:0] M_COLL  = 16'h000F;
	// reset values
	localparam logic [15:0] CMD_RST = 16'h0000;
	localparam logic [13:0] CNT_RST = 14'h0000;
	localparam logic [1:0]  CFG_RST = 2'h1;
	// timing counts in pclk cycles, then the collision retry limit
	localparam logic [15:0] PREAMBLE_CYC = 16'h0040;
	localparam logic [15:0] SLOT_CYC     = 16'h0200;
	localparam logic [15:0] BACKOFF_CYC  = 16'h0200;
	localparam logic [3:0]  MAX_RETRY    = 4'hF;
	// synchronised link pins
	typedef struct packed {
		logic carrier_present;
		logic clear_to_send;
		logic collision;
		logic link_busy;
	} tcs_link_type;
	typedef enum logic [2:0] {S_IDLE, S_DEFER, S_PRE, S_DATA, S_BACKOFF} tcs_state_type;
endpackage : tcs_pkg

/* File: verilog/tcs_tx_command_status.sv */
// tcs_tx_command_status: transmit command decode, frame sequencer and status word
// assumes: APB master on pclk, link pins asynchronous, dma strobes on pclk
`timescale 1ns/1ps
module tcs_tx_command_status (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire tcs_pkg::tcs_link_type link_pins,
	input  wire logic                dma_ready,
	input  wire logic                dma_last,
	output logic                     tx_en,
	output logic                     append_crc,
	output logic                     use_desc,
	output logic                     irq
);
	import tcs_pkg::*;

	tcs_link_type  sync1_q, lnk_q;
	tcs_state_type state_q;
	logic [15:0]   cmd_q, status_q, cnt_q;
	logic [31:0]   desc_q;
	logic [13:0]   count_q, byte_q;
	logic [1:0]    cfg_q, irq_st_q, irq_msk_q;
	logic [31:0]   prdata_q;
	logic          pready_q, pslverr_q, abort_q, done_q, ok_q;
	logic          tx_en_q, append_crc_q, use_desc_q, irq_q;
	logic          acc, wr, go, busy;

	// finished status word: done set, busy cleared, outcome bits merged
	function automatic logic [15:0] fin(input logic [15:0] s, input logic [15:0] set,
		input logic ok);
		fin = (s | set | M_DONE) & ~M_BUSY & ~M_OK;
		if (ok) begin
			fin = fin | M_OK;
		end
	endfunction : fin

	//////////////////////////////////////////////////////////////////////////
	// apb slave
	assign acc  = psel && penable && pready_q;
	assign wr   = acc && pwrite;
	assign busy = (state_q != S_IDLE);
	assign go   = wr && (paddr == ADDR_CMD) && !busy;

	// answer one cycle after setup; read data captured in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= psel && !penable;
			pslverr_q <= 1'b0;
			if (psel && !penable) begin
				prdata_q <= 32'h00000000;
				case (paddr)
					ADDR_CMD:     prdata_q <= {cmd_q, status_q};
					ADDR_DESC:    prdata_q <= desc_q;
					ADDR_COUNT:   prdata_q <= {18'h00000, count_q};
					ADDR_CFG:     prdata_q <= {30'h00000000, cfg_q};
					ADDR_STATUS:  prdata_q <= {16'h0000, status_q};
					ADDR_CTRL:    prdata_q <= 32'h00000000;
					ADDR_IRQ_ST:  prdata_q <= {30'h00000000, irq_st_q};
					ADDR_IRQ_MSK: prdata_q <= {30'h00000000, irq_msk_q};
					default:      pslverr_q <= 1'b1;
				endcase
			end
		end
	end

	// software registers; command word writes ignored while busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q     <= CMD_RST;
			desc_q    <= DESC_NONE;
			count_q   <= CNT_RST;
			cfg_q     <= CFG_RST;
			irq_msk_q <= 2'h0;
			abort_q   <= 1'b0;
		end else begin
			abort_q <= wr && (paddr == ADDR_CTRL) && pwdata[0];
			if (go) begin
				cmd_q <= pwdata[31:16]; // reserved bits stored as written
			end
			if (wr && !busy && paddr == ADDR_DESC) begin
				desc_q <= pwdata;
			end
			if (wr && !busy && paddr == ADDR_COUNT) begin
				count_q <= pwdata[13:0];
			end
			if (wr && paddr == ADDR_CFG) begin
				cfg_q <= pwdata[1:0];
			end
			if (wr && paddr == ADDR_IRQ_MSK) begin
				irq_msk_q <= pwdata[1:0];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// link pin synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			lnk_q   <= '0;
		end else begin
			sync1_q <= link_pins;
			lnk_q   <= sync1_q;
		end
	end

	// frame options latched at the start of a command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			append_crc_q <= 1'b0;
			use_desc_q   <= 1'b0;
		end else if (go) begin
			append_crc_q <= pwdata[NOCRC_BIT] ? 1'b0 : cfg_q[CFG_CRC_BIT];
			use_desc_q   <= pwdata[FLEX_BIT] && (desc_q != DESC_NONE);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// frame sequencer and status word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q  <= S_IDLE;
			status_q <= 16'h0000;
			cnt_q    <= 16'h0000;
			byte_q   <= 14'h0000;
			done_q   <= 1'b0;
			ok_q     <= 1'b0;
		end else begin
			done_q <= 1'b0;
			cnt_q  <= cnt_q + 16'h0001;
			if (busy && abort_q) begin
				status_q <= fin(status_q, M_ABORT, 1'b0);
				state_q  <= S_IDLE;
				done_q   <= 1'b1;
				ok_q     <= 1'b0;
			end else begin
				case (state_q)
					S_IDLE: begin
						cnt_q  <= 16'h0000;
						byte_q <= 14'h0000;
						if (go && pwdata[CMD_CODE_LSB +: 3] != CMD_TX) begin
							status_q <= fin(16'h0000, 16'h0000, 1'b0);
							done_q   <= 1'b1;
							ok_q     <= 1'b0;
						end else if (go && lnk_q.link_busy) begin
							status_q <= M_BUSY | M_DEFER;
							state_q  <= S_DEFER;
						end else if (go) begin
							status_q <= M_BUSY;
							state_q  <= S_PRE;
						end
					end
					S_DEFER: begin
						cnt_q <= 16'h0000;
						if (!lnk_q.link_busy) begin
							state_q <= S_PRE;
						end
					end
					S_PRE: begin
						if (!lnk_q.clear_to_send) begin
							status_q <= fin(status_q, M_CTS, 1'b0);
							state_q  <= S_IDLE;
							done_q   <= 1'b1;
							ok_q     <= 1'b0;
						end else if (cnt_q == PREAMBLE_CYC - 16'h0001) begin
							state_q <= S_DATA;
						end
					end
					S_DATA: begin
						if (!lnk_q.clear_to_send) begin
							status_q <= fin(status_q, M_CTS, 1'b0);
							state_q  <= S_IDLE;
							done_q   <= 1'b1;
							ok_q     <= 1'b0;
						end else if (lnk_q.collision && cnt_q >= SLOT_CYC) begin
							status_q <= fin(status_q, M_LATE, 1'b0);
							state_q  <= S_IDLE;
							done_q   <= 1'b1;
							ok_q     <= 1'b0;
						end else if (lnk_q.collision && status_q[3:0] == MAX_RETRY) begin
							status_q <= fin(status_q & ~M_COLL, M_RETRY, 1'b0);
							state_q  <= S_IDLE;
							done_q   <= 1'b1;
							ok_q     <= 1'b0;
						end else if (lnk_q.collision) begin
							status_q[3:0] <= status_q[3:0] + 4'h1;
							state_q       <= S_BACKOFF;
							cnt_q         <= 16'h0000;
						end else if (!dma_ready) begin
							status_q <= fin(status_q, M_UNDER, 1'b0);
							state_q  <= S_IDLE;
							done_q   <= 1'b1;
							ok_q     <= 1'b0;
						end else if (!lnk_q.carrier_present && !cfg_q[CFG_NOCRS_BIT]) begin
							status_q <= fin(status_q, M_NOCRS, 1'b0);
							state_q  <= S_IDLE;
							done_q   <= 1'b1;
							ok_q     <= 1'b0;
						end else begin
							byte_q <= byte_q + 14'h0001;
							if (use_desc_q ? dma_last : (byte_q + 14'h0001 >= count_q)) begin
								// carrier-less mode finishes but keeps the flag
								status_q <= fin(status_q,
									lnk_q.carrier_present ? 16'h0000 : M_NOCRS,
									1'b1);
								state_q  <= S_IDLE;
								done_q   <= 1'b1;
								ok_q     <= 1'b1;
							end else if (!lnk_q.carrier_present) begin
								status_q <= status_q | M_NOCRS;
							end
						end
					end
					S_BACKOFF: begin
						byte_q <= 14'h0000;
						if (cnt_q == BACKOFF_CYC - 16'h0001) begin
							state_q <= S_PRE;
							cnt_q   <= 16'h0000;
						end
					end
					default: state_q <= S_IDLE;
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// interrupt: bit0 done, bit1 failed; set wins over write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st_q <= 2'h0;
			irq_q    <= 1'b0;
		end else begin
			irq_st_q <= (irq_st_q & ~((wr && paddr == ADDR_IRQ_ST) ? pwdata[1:0] : 2'h0))
				| {done_q && !ok_q, done_q};
			irq_q    <= |(irq_st_q & irq_msk_q);
		end
	end

	// transmit enable follows the sequencer one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_en_q <= 1'b0;
		end else begin
			tx_en_q <= (state_q == S_PRE) || (state_q == S_DATA);
		end
	end

	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign tx_en      = tx_en_q;
	assign append_crc = append_crc_q;
	assign use_desc   = use_desc_q;
	assign irq        = irq_q;

	//////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_go_tx;
		go && pwdata[CMD_CODE_LSB +: 3] == CMD_TX;
	endsequence
	sequence s_finished(logic [15:0] m);
		state_q == S_IDLE && (status_q & (m | M_DONE)) == (m | M_DONE) && !status_q[14];
	endsequence

	property p_cmd_code;
		go && pwdata[CMD_CODE_LSB +: 3] != CMD_TX |=> state_q == S_IDLE && status_q == M_DONE;
	endproperty
	a_cmd_code: assert property (p_cmd_code) else $error("bad code not rejected");
	property p_crc_off;
		s_go_tx ##0 !cfg_q[CFG_CRC_BIT] |=> !append_crc_q;
	endproperty
	a_crc_off: assert property (p_crc_off) else $error("crc appended while off");
	property p_crc_on;
		go && cfg_q[CFG_CRC_BIT] |=> append_crc_q == !$past(pwdata[NOCRC_BIT]);
	endproperty
	a_crc_on: assert property (p_crc_on) else $error("crc choice wrong");
	property p_layout;
		go |=> use_desc_q == ($past(pwdata[FLEX_BIT]) && desc_q != DESC_NONE);
	endproperty
	a_layout: assert property (p_layout) else $error("layout choice wrong");
	property p_abort;
		busy && abort_q |=> s_finished(M_ABORT) ##0 !status_q[13];
	endproperty
	a_abort: assert property (p_abort) else $error("abort not reported");
	property p_late;
		state_q == S_DATA && !abort_q && lnk_q.clear_to_send && lnk_q.collision
			&& cnt_q >= SLOT_CYC
			|=> s_finished(M_LATE);
	endproperty
	a_late: assert property (p_late) else $error("late collision missed");
	property p_nocrs_stop;
		state_q == S_DATA && !abort_q && !cfg_q[CFG_NOCRS_BIT] && !lnk_q.carrier_present
			&& lnk_q.clear_to_send && !lnk_q.collision && dma_ready
			|=> s_finished(M_NOCRS) ##0 !status_q[13];
	endproperty
	a_nocrs_stop: assert property (p_nocrs_stop) else $error("no stop on carrier loss");
	property p_nocrs_flag;
		state_q == S_DATA && !abort_q && cfg_q[CFG_NOCRS_BIT] && !lnk_q.carrier_present
			&& lnk_q.clear_to_send && !lnk_q.collision && dma_ready
			|=> status_q[10] && (state_q == S_DATA || status_q[13]);
	endproperty
	a_nocrs_flag: assert property (p_nocrs_flag) else $error("carrier flag wrong");
	property p_cts;
		(state_q == S_PRE || state_q == S_DATA) && !abort_q && !lnk_q.clear_to_send
			|=> s_finished(M_CTS);
	endproperty
	a_cts: assert property (p_cts) else $error("cts loss not stopped");
	property p_under;
		state_q == S_DATA && !abort_q && lnk_q.clear_to_send && !lnk_q.collision && !dma_ready
			|=> s_finished(M_UNDER);
	endproperty
	a_under: assert property (p_under) else $error("underrun not stopped");
	property p_defer;
		s_go_tx ##0 lnk_q.link_busy |=> state_q == S_DEFER && status_q[7];
	endproperty
	a_defer: assert property (p_defer) else $error("deferral not flagged");
	property p_retry;
		state_q == S_DATA && !abort_q && lnk_q.clear_to_send && lnk_q.collision
			&& cnt_q < SLOT_CYC && status_q[3:0] == MAX_RETRY
			|=> s_finished(M_RETRY) ##0 status_q[3:0] == 4'h0;
	endproperty
	a_retry: assert property (p_retry) else $error("retry limit wrong");
	property p_done_status;
		done_q |-> status_q[15] && !status_q[14] && status_q[13] == ok_q;
	endproperty
	a_done_status: assert property (p_done_status) else $error("stale status");
endmodule : tcs_tx_command_status

/* File: test/tcs_link_model.sv */
// tcs_link_model: behavioural transceiver and host memory on the far side of the block
// assumes: tx_en from the block, fault controls from the bench, all on pclk
`timescale 1ns/1ps
module tcs_link_model #(
	parameter logic [15:0] LAST_AT = 16'h005A
) (
	input  wire logic             pclk,
	input  wire logic             tx_en,
	input  wire logic             desc_mode,
	input  wire logic             busy,
	input  wire logic [2:0]       fault,
	input  wire logic [15:0]      fault_at,
	input  wire logic [4:0]       coll_lim,
	output tcs_pkg::tcs_link_type link_pins,
	output logic                  dma_ready,
	output logic                  dma_last
);
	import tcs_pkg::*;
	logic [15:0] txcnt_q;
	logic [4:0]  ncoll_q;
	logic        hit;
	logic        coll;
	////////////////////////////////////////////////////////////////////////////////
	// cycles of the current attempt, restarting with every fresh attempt
	always_ff @(posedge pclk) begin
		txcnt_q <= tx_en ? txcnt_q + 16'h0001 : 16'h0000;
	end
	assign hit  = (fault_at != 16'h0000) && (txcnt_q >= fault_at);
	assign coll = (fault == 3'h4) && (txcnt_q == fault_at) && (ncoll_q < coll_lim);
	// one collision per attempt until the limit is spent; limit 0 rearms
	always_ff @(posedge pclk) begin
		if (coll_lim == 5'h00) begin
			ncoll_q <= 5'h00;
		end else if (coll) begin
			ncoll_q <= ncoll_q + 5'h01;
		end
	end
	// line levels: carrier echoes our own transmission or foreign traffic
	always_comb begin
		link_pins.link_busy       = busy;
		link_pins.carrier_present = busy | (tx_en & !(fault == 3'h1 && hit));
		link_pins.clear_to_send   = !(fault == 3'h2 && hit);
		link_pins.collision       = coll;
		dma_ready                 = !(fault == 3'h3 && hit);
		dma_last                  = desc_mode && (txcnt_q >= LAST_AT);
	end
endmodule : tcs_link_model

/* File: test/tcs_tx_command_status_test.sv */
// tcs_tx_command_status_test: register-level bench of the transmit command/status block
// assumes: link model on the far side, APB master tasks, one 250 MHz clock
`timescale 1ns/1ps
module tcs_tx_command_status_test;
	import tcs_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic         tx_en, append_crc, use_desc, dma_ready, dma_last, busy, seen_crc, seen_desc;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [2:0]   fault;
	logic [15:0]  fault_at;
	logic [4:0]   coll_lim;
	tcs_link_type link_pins;
	int           n_mismatch, samples_checked;
	////////////////////////////////////////////////////////////////////////////////
	tcs_tx_command_status tcs_tx_command_status_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link_pins(link_pins),
		.dma_ready(dma_ready), .dma_last(dma_last), .tx_en(tx_en),
		.append_crc(append_crc), .use_desc(use_desc), .irq(irq));
	tcs_link_model tcs_link_model_inst (.pclk(pclk), .tx_en(tx_en), .desc_mode(use_desc),
		.busy(busy), .fault(fault), .fault_at(fault_at), .coll_lim(coll_lim),
		.link_pins(link_pins), .dma_ready(dma_ready), .dma_last(dma_last));
	// clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// remember the frame options seen while transmitting
	always @(posedge pclk) begin
		if (tx_en === 1'b1) begin
			seen_crc  <= append_crc;
			seen_desc <= use_desc;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	// one APB transfer; holds the request until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) n_mismatch++;
	endtask : apb
	task rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h00000000);
		check(nm, rd, exp);
	endtask : rdchk
	// issue one command with a far-side fault, optionally abort, poll and compare status
	task run(input logic [31:0] cmd, input logic [2:0] f, input logic [15:0] at,
		input logic [4:0] lim, input logic ab, input logic [15:0] mask,
		input logic [15:0] exp, input string nm);
		int n;
		fault    <= f;
		fault_at <= at;
		coll_lim <= lim;
		apb(1'b1, ADDR_CMD, cmd);
		n = 0;
		while (ab && tx_en !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		if (ab) apb(1'b1, ADDR_CTRL, 32'h00000001);
		n = 0;
		do begin
			apb(1'b0, ADDR_STATUS, 32'h00000000);
			n++;
		end while (rd[15] !== 1'b1 && n < 20000);
		coll_lim <= 5'h00;
		fault    <= 3'h0;
		check(nm, {16'h0000, rd[15:0] & mask}, {16'h0000, exp});
		// one edge with the limit at zero rearms the model's collision tally
		@(posedge pclk);
	endtask : run
	task complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake or sequencer
	initial begin
		repeat (80000) @(posedge pclk);
		n_mismatch++;
		complete_run;
	end
	// main sequence
	initial begin
		n_mismatch = 0;
		samples_checked = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, busy} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		fault = 3'h0;
		fault_at = 16'h0000;
		coll_lim = 5'h00;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(ADDR_CFG, 32'h00000001, "cfg reset");
		rdchk(ADDR_DESC, DESC_NONE, "pointer reset");
		rdchk(ADDR_COUNT, 32'h00000000, "count reset");
		rdchk(ADDR_STATUS, 32'h00000000, "status reset");
		rdchk(8'h20, 32'h00000000, "unmapped read");
		check("unmapped error", {31'h0, err}, 32'h00000001);
		apb(1'b1, ADDR_IRQ_MSK, 32'h00000001);
		apb(1'b1, ADDR_COUNT, 32'h00000028);
		run(32'h00040000, 3'h0, 16'h0000, 5'h00, 1'b0, 16'hFFFF, M_DONE | M_OK, "plain");
		check("crc on", {31'h0, seen_crc}, 32'h00000001);
		check("no desc", {31'h0, seen_desc}, 32'h00000000);
		check("irq up", {31'h0, irq}, 32'h00000001);
		apb(1'b1, ADDR_IRQ_ST, 32'h00000001);
		repeat (2) @(posedge pclk);
		check("irq clear", {31'h0, irq}, 32'h00000000);
		run(32'h00140000, 3'h0, 16'h0000, 5'h00, 1'b0, 16'hFFFF, M_DONE | M_OK, "nocrc");
		check("crc dropped", {31'h0, seen_crc}, 32'h00000000);
		apb(1'b1, ADDR_CFG, 32'h00000000);
		run(32'h00040000, 3'h0, 16'h0000, 5'h00, 1'b0, 16'hFFFF, M_DONE | M_OK, "crc off");
		check("crc global off", {31'h0, seen_crc}, 32'h00000000);
		apb(1'b1, ADDR_CFG, 32'h00000001);
		apb(1'b1, ADDR_DESC, 32'h00001000);
		run(32'h000C0000, 3'h0, 16'h0000, 5'h00, 1'b0, 16'hFFFF, M_DONE | M_OK, "flex");
		check("desc used", {31'h0, seen_desc}, 32'h00000001);
		apb(1'b1, ADDR_DESC, DESC_NONE);
		run(32'h000C0000, 3'h0, 16'h0000, 5'h00, 1'b0, 16'hFFFF, M_DONE | M_OK, "flex none");
		check("no pointer no desc", {31'h0, seen_desc}, 32'h00000000);
		apb(1'b1, ADDR_IRQ_ST, 32'h00000003);
		run(32'h00030000, 3'h0, 16'h0000, 5'h00, 1'b0, 16'hFFFF, M_DONE, "bad code");
		rdchk(ADDR_IRQ_ST, 32'h00000003, "failed flag");
		run(32'h00040000, 3'h1, 16'h0050, 5'h00, 1'b0, 16'hFFFF, M_DONE | M_NOCRS, "crs0");
		apb(1'b1, ADDR_CFG, 32'h00000003);
		run(32'h00040000, 3'h1, 16'h0050, 5'h00, 1'b0, 16'hFFFF,
			M_DONE | M_OK | M_NOCRS, "crs1");
		apb(1'b1, ADDR_CFG, 32'h00000001);
		run(32'h00040000, 3'h2, 16'h0050, 5'h00, 1'b0, 16'hFFFF, M_DONE | M_CTS, "cts");
		run(32'h00040000, 3'h3, 16'h0050, 5'h00, 1'b0, 16'hFFFF, M_DONE | M_UNDER, "dma");
		run(32'h00040000, 3'h4, 16'h0050, 5'h01, 1'b0, 16'hFFFF,
			M_DONE | M_OK | 16'h0001, "one collision");
		run(32'h00040000, 3'h4, 16'h0050, 5'h10, 1'b0, 16'hFFFF,
			M_DONE | M_RETRY, "retry limit");
		apb(1'b1, ADDR_COUNT, 32'h000003E8);
		run(32'h00040000, 3'h4, 16'h0258, 5'h01, 1'b0, M_DONE | M_OK | M_LATE,
			M_DONE | M_LATE, "late");
		apb(1'b1, ADDR_COUNT, 32'h00000028);
		busy <= 1'b1;
		fork
			run(32'h00040000, 3'h0, 16'h0000, 5'h00, 1'b0, 16'hFFFF,
				M_DONE | M_OK | M_DEFER, "defer");
			begin
				repeat (40) @(posedge pclk);
				busy <= 1'b0;
			end
		join
		run(32'h00040000, 3'h0, 16'h0000, 5'h00, 1'b1, M_DONE | M_OK | M_ABORT,
			M_DONE | M_ABORT, "abort");
		complete_run;
	end
endmodule : tcs_tx_command_status_test
